// ===== rtl/rsfc_top.sv
// Purpose: reset source logic, cause flags and trip threshold selection
// Assumes: watchdog, comparator and CPU live outside; mode input is clk-synchronous
// Notes: rst_n is the power-on reset; every other reset is issued from here
// Function
// - four threshold patterns select the trip level
// - undefined threshold pattern: delayed full reset, restore
// - filtered undervoltage gives full reset, threshold kept
// - undervoltage cause flag bit 2, zero-write clears
// - threshold corrupt flag bit 1, zero-write clears
// - upper four flag bits read zero
// - run-mode watchdog gives full reset and threshold restore, sets timeout
// - sleep watchdog clears counter and stack only
// - timeout and power-down flag update per reset
// - power-on reset initialises core state
// - full resets load the guard word default, sleep watchdog keeps it
// - guard word corrupt flag bit 3, software clears
// - watchdog word corrupt flag bit 0, software clears
`timescale 1ns/1ns
module rsfc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [rsfc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rsfc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic supplyLow,
  input wire logic sleepMode,
  input wire logic wdtTimeout,
  input wire logic wdtWordBad,
  input wire logic haltEntry,
  input wire logic wdtClear,
  output logic [rsfc_pkg::DATA_W-1:0] regRdata,
  output logic [1:0] tripLevel,
  output logic lvrEnable,
  output logic systemReset,
  output logic pcStackClear,
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic irq
);
  import rsfc_pkg::*;

  // reset release
  logic rstMeta; // first stage, read only by the second
  logic rstN; // released copy used by the rest of the block

  // registers
  logic [7:0] thresholdSel; // threshold_select_reg
  logic [7:0] guardWord; // reset_guard_word
  logic [3:0] causeFlags; // reset_flag_reg low nibble
  logic [IRQ_N-1:0] irqStat; // sticky events
  logic [IRQ_N-1:0] irqMask; // event enables

  // internal state
  logic supplyLowSync; // filtered comparator level
  logic wdtWordPend; // watchdog word fault waiting for its delay
  logic [2:0] holdCount; // remaining full-reset cycles
  // decoded views of the guarded registers
  logic thrValid;
  rsfc_level_t thrLevel;
  logic guardValid;
  // reset sources and their timers
  logic softArm;
  logic softDone;
  logic uvDone;
  logic runWdt;
  logic sleepWdt;
  logic fullReset;
  logic thrRestore;
  // event strobes and write decodes
  logic [IRQ_N-1:0] events;
  logic wrThr;
  logic wrFlags;
  logic wrGuard;
  logic wrIrqStat;
  logic wrIrqMask;

  // pattern decode for the trip level, reused for check and select
  function automatic logic thr_valid(input logic [7:0] code);
    return (code == TRIP_2V10) || (code == TRIP_2V55) ||
           (code == TRIP_3V15) || (code == TRIP_3V80);
  endfunction

  function automatic rsfc_level_t thr_level(input logic [7:0] code);
    rsfc_level_t lvl;
    lvl = RSFC_LVL_2V10;
    case (code)
      TRIP_2V55: lvl = RSFC_LVL_2V55;
      TRIP_3V15: lvl = RSFC_LVL_3V15;
      TRIP_3V80: lvl = RSFC_LVL_3V80;
      default: lvl = RSFC_LVL_2V10;
    endcase
    return lvl;
  endfunction

  // two-flop release of the power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // comparator output is asynchronous to clk
  rsfc_sync3 uSupplySync (
    .clk(clk),
    .rstN(rstN),
    .async(supplyLow),
    .level(supplyLowSync)
  );

  // continuous pattern checks, no register access needed
  assign thrValid = thr_valid(thresholdSel);
  assign thrLevel = thr_level(thresholdSel);
  assign guardValid = (guardWord == GUARD_NOP_A) || (guardWord == GUARD_NOP_B);

  // address decode
  assign wrThr = regWrite && (regAddr == OFS_THRESHOLD);
  assign wrFlags = regWrite && (regAddr == OFS_FLAGS);
  assign wrGuard = regWrite && (regAddr == OFS_GUARD);
  assign wrIrqStat = regWrite && (regAddr == OFS_IRQ_STAT);
  assign wrIrqMask = regWrite && (regAddr == OFS_IRQ_MASK);

  // any software-type fault waits out the soft reset delay
  assign softArm = !thrValid || !guardValid || wdtWordPend;

  rsfc_delay #(
    .CYCLES(SOFT_RESET_CYC)
  ) uSoftDelay (
    .clk(clk),
    .rstN(rstN),
    .arm(softArm),
    .done(softDone)
  );

  // undervoltage must persist the filter time; the detector sleeps with the core
  rsfc_delay #(
    .CYCLES(UV_FILTER_CYC)
  ) uUvFilter (
    .clk(clk),
    .rstN(rstN),
    .arm(supplyLowSync && !sleepMode),
    .done(uvDone)
  );

  // watchdog time-out splits by operating mode
  assign runWdt = wdtTimeout && !sleepMode;
  assign sleepWdt = wdtTimeout && sleepMode;

  // full reset sources; the sleep case is deliberately absent
  assign fullReset = uvDone || softDone || runWdt;

  // threshold reloads on a soft fault or a run-mode watchdog, not on undervoltage
  assign thrRestore = softDone || runWdt;

  // event vector for the interrupt status
  always_comb begin
    events = '0;
    events[EV_UV] = uvDone;
    events[EV_THR] = !thrValid;
    events[EV_GUARD] = !guardValid;
    events[EV_WDT_WORD] = wdtWordBad;
    events[EV_TIMEOUT] = wdtTimeout;
  end

  // threshold select register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      thresholdSel <= THRESHOLD_POR;
    end else if (thrRestore) begin
      // restore outranks a software write in the same cycle
      thresholdSel <= THRESHOLD_POR;
    end else if (wrThr && !fullReset) begin
      // undervoltage reset and sleep watchdog leave it alone
      thresholdSel <= regWdata;
    end
  end

  // selected level to the comparator, held while a pattern is invalid
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tripLevel <= RSFC_LVL_2V10;
    end else if (thrValid) begin
      tripLevel <= thrLevel;
    end
  end

  // detector is active only in the fast and slow modes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lvrEnable <= 1'b0;
    end else begin
      lvrEnable <= !sleepMode;
    end
  end

  // guard word: reloads on every full reset, kept by sleep watchdog
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      guardWord <= GUARD_POR;
    end else if (fullReset) begin
      guardWord <= GUARD_POR;
    end else if (wrGuard) begin
      guardWord <= regWdata;
    end
  end

  // watchdog word fault is a pulse; hold it until its delayed reset fires
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wdtWordPend <= 1'b0;
    end else if (wdtWordBad) begin
      wdtWordPend <= 1'b1;
    end else if (fullReset) begin
      wdtWordPend <= 1'b0;
    end
  end

  // cause flags: only power-on clears them by hardware, so a flag
  // raised by a reset is not wiped by that same reset
  // a written zero clears, a written one keeps; a set in the same cycle wins
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      causeFlags <= 4'h0;
    end else begin
      // software clear first; a set below in the same cycle overrides it
      for (int i = 0; i < 4; i++) begin
        if (wrFlags && !regWdata[i]) begin
          causeFlags[i] <= 1'b0;
        end
      end
      if (uvDone) begin
        causeFlags[FLG_UV] <= 1'b1;
      end
      if (!thrValid) begin
        causeFlags[FLG_THR] <= 1'b1;
      end
      if (!guardValid) begin
        causeFlags[FLG_GUARD] <= 1'b1;
      end
      if (wdtWordBad) begin
        causeFlags[FLG_WDT_WORD] <= 1'b1;
      end
    end
  end

  // timeout and power-down: zero at power-on, untouched by undervoltage
  // a time-out outranks halt and clear arriving in the same cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      timeoutFlag <= 1'b0;
      powerDownFlag <= 1'b0;
    end else if (wdtTimeout) begin
      timeoutFlag <= 1'b1;
      // only a watchdog from sleep or idle marks power-down
      powerDownFlag <= sleepWdt ? 1'b1 : powerDownFlag;
    end else if (haltEntry) begin
      powerDownFlag <= 1'b1;
    end else if (wdtClear) begin
      // clearing the watchdog also clears both status flags
      timeoutFlag <= 1'b0;
      powerDownFlag <= 1'b0;
    end
  end

  // full reset pulse to the core: counter zero, interrupts off, timers off,
  // ports to inputs, stack to top; held for a few cycles, restarted on a new cause
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      holdCount <= 3'(RESET_HOLD_CYC);
      systemReset <= 1'b1;
    end else if (fullReset) begin
      // a fresh cause restarts the count, so overlapping causes stretch the pulse
      holdCount <= 3'(RESET_HOLD_CYC - 1);
      systemReset <= 1'b1;
    end else if (holdCount != 3'h0) begin
      holdCount <= holdCount - 3'h1;
      systemReset <= 1'b1;
    end else begin
      systemReset <= 1'b0;
    end
  end

  // sleep watchdog: one pulse clearing program counter and stack pointer only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pcStackClear <= 1'b0;
    end else begin
      pcStackClear <= sleepWdt && !fullReset;
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqMask <= '0;
    end else if (wrIrqMask) begin
      irqMask <= regWdata[IRQ_N-1:0];
    end
  end

  // sticky events, write one to clear, set beats clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqStat <= '0;
    end else begin
      irqStat <= (irqStat & ~(wrIrqStat ? regWdata[IRQ_N-1:0] : '0)) | events;
    end
  end

  // level interrupt, registered so it lags status by one cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= '0;
    end else if (regRead) begin
      // short registers are zero-padded into the byte
      case (regAddr)
        OFS_THRESHOLD: regRdata <= thresholdSel;
        OFS_FLAGS: regRdata <= {4'h0, causeFlags};
        OFS_GUARD: regRdata <= guardWord;
        OFS_STATUS: regRdata <= {6'h00, powerDownFlag, timeoutFlag};
        OFS_IRQ_STAT: regRdata <= {3'h0, irqStat};
        OFS_IRQ_MASK: regRdata <= {3'h0, irqMask};
        default: regRdata <= 8'h00; // unmapped reads as zero
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

// ===== rtl/rsfc_pkg.sv
// Purpose: shared constants for the reset source and flag controller
// Assumes: 50 MHz system clock, byte-wide register port with 4-bit address
// Notes: all offsets, fields, reset values and timing counts live here
package rsfc_pkg;

  // clock figures
  localparam int unsigned CLK_PERIOD_NS = 20; // 50 MHz system clock

  // printed timing has no figure here; plain defaults, see hand-over
  localparam int unsigned UV_FILTER_NS = 60000; // undervoltage_filter_time
  localparam int unsigned SOFT_RESET_NS = 40000; // soft_reset_delay

  // least times round up to whole cycles, never below one
  function automatic int unsigned rsfc_cycles_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned UV_FILTER_CYC = rsfc_cycles_ceil(UV_FILTER_NS);
  localparam int unsigned SOFT_RESET_CYC = rsfc_cycles_ceil(SOFT_RESET_NS);
  localparam int unsigned RESET_HOLD_CYC = 4; // width of the full reset pulse
  localparam int unsigned DELAY_W = 16; // delay counter width

  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] OFS_THRESHOLD = 4'h0; // threshold_select_reg
  localparam logic [3:0] OFS_FLAGS = 4'h1; // reset_flag_reg
  localparam logic [3:0] OFS_GUARD = 4'h2; // reset_guard_word
  localparam logic [3:0] OFS_STATUS = 4'h3; // timeout / power-down flags
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4; // sticky event bits
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5; // event enables

  // reset values
  localparam logic [7:0] THRESHOLD_POR = 8'h55;
  localparam logic [7:0] GUARD_POR = 8'h55;
  localparam logic [7:0] GUARD_NOP_A = 8'h55;
  localparam logic [7:0] GUARD_NOP_B = 8'haa;

  // trip_level_code patterns
  localparam logic [7:0] TRIP_2V10 = 8'h55; // 01010101
  localparam logic [7:0] TRIP_2V55 = 8'h33; // 00110011
  localparam logic [7:0] TRIP_3V15 = 8'h99; // 10011001
  localparam logic [7:0] TRIP_3V80 = 8'haa; // 10101010

  // reset_flag_reg fields
  localparam int unsigned FLG_WDT_WORD = 0; // watchdog_word_corrupt_flag
  localparam int unsigned FLG_THR = 1; // threshold_corrupt_flag
  localparam int unsigned FLG_UV = 2; // undervoltage_cause_flag
  localparam int unsigned FLG_GUARD = 3; // reset_word_corrupt_flag

  // status register fields
  localparam int unsigned STS_TIMEOUT = 0; // watchdog_timeout_flag
  localparam int unsigned STS_PDOWN = 1; // power_down_flag

  // interrupt event bits
  localparam int unsigned IRQ_N = 5;
  localparam int unsigned EV_UV = 0;
  localparam int unsigned EV_THR = 1;
  localparam int unsigned EV_GUARD = 2;
  localparam int unsigned EV_WDT_WORD = 3;
  localparam int unsigned EV_TIMEOUT = 4;

  // selected trip level as a 2-bit index to the comparator
  typedef enum logic [1:0] {
    RSFC_LVL_2V10 = 2'h0,
    RSFC_LVL_2V55 = 2'h1,
    RSFC_LVL_3V15 = 2'h2,
    RSFC_LVL_3V80 = 2'h3
  } rsfc_level_t;

endpackage

// ===== rtl/rsfc_sync3.sv
// Purpose: three-stage synchroniser for one asynchronous level
// Assumes: input may change at any time relative to clk
// Notes: output follows only when stages two and three agree
`timescale 1ns/1ns
module rsfc_sync3 (
  input wire logic clk,
  input wire logic rstN,
  input wire logic async,
  output logic level
);
  logic s1; // metastable stage, read only by s2
  logic s2;
  logic s3;

  // shift chain
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a change once two settled stages agree
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// ===== rtl/rsfc_delay.sv
// Purpose: armed delay timer, one pulse after a level stays high long enough
// Assumes: arm comes from logic on the same clock
// Notes: dropping arm restarts the count; fires once per armed period
`timescale 1ns/1ns
module rsfc_delay #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic arm,
  output logic done
);
  import rsfc_pkg::*;

  localparam logic [DELAY_W-1:0] LAST = DELAY_W'(CYCLES - 1);

  logic [DELAY_W-1:0] count; // cycles spent armed
  logic fired; // blocks repeat pulses while arm stays high

  // counter and one-shot
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
      fired <= 1'b0;
      done <= 1'b0;
    end else if (!arm) begin
      count <= '0;
      fired <= 1'b0;
      done <= 1'b0;
    end else if (!fired && count == LAST) begin
      fired <= 1'b1;
      done <= 1'b1;
    end else begin
      count <= fired ? count : count + 1'b1;
      done <= 1'b0;
    end
  end
endmodule

// ===== tb/rsfc_checker.sv
// Purpose: port-level checks for the reset source and flag controller
// Assumes: sees only the top module ports, one clock domain
// Notes: attached by the bind at the foot of this file
`timescale 1ns/1ns
module rsfc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [rsfc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rsfc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic supplyLow,
  input wire logic sleepMode,
  input wire logic wdtTimeout,
  input wire logic wdtWordBad,
  input wire logic haltEntry,
  input wire logic wdtClear,
  input wire logic [rsfc_pkg::DATA_W-1:0] regRdata,
  input wire logic [1:0] tripLevel,
  input wire logic lvrEnable,
  input wire logic systemReset,
  input wire logic pcStackClear,
  input wire logic timeoutFlag,
  input wire logic powerDownFlag,
  input wire logic irq
);
  import rsfc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // watchdog events split by core mode
  sequence sleepWdt;
    wdtTimeout && sleepMode && !systemReset;
  endsequence
  sequence runWdt;
    wdtTimeout && !sleepMode;
  endsequence
  // a full reset stands exactly four cycles
  sequence fullPulse;
    systemReset [*4] ##1 !systemReset;
  endsequence
  rdata_idle_a: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  flag_upper_a: assert property (regRead && regAddr == OFS_FLAGS |=> regRdata[7:4] == 4'h0)
    else $error("upper flag bits not zero");
  trip_decode_a: assert property (regWrite && regAddr == OFS_THRESHOLD &&
    regWdata == TRIP_3V15 && !systemReset |-> ##[1:3] tripLevel == 2'h2)
    else $error("trip level not decoded");
  sleep_wdt_a: assert property (sleepWdt |=> pcStackClear && timeoutFlag && powerDownFlag)
    else $error("sleep watchdog answer wrong");
  sleep_keep_a: assert property (sleepWdt |=> !systemReset [*2])
    else $error("sleep watchdog gave a full reset");
  run_wdt_a: assert property (runWdt |=> systemReset && timeoutFlag && !pcStackClear)
    else $error("run watchdog answer wrong");
  pdf_keep_a: assert property (runWdt |=> powerDownFlag == $past(powerDownFlag))
    else $error("power-down flag changed by run watchdog");
  clear_pulse_a: assert property (pcStackClear |=> !pcStackClear)
    else $error("counter clear longer than one cycle");
  reset_len_a: assert property ($rose(systemReset) |-> fullPulse)
    else $error("full reset length wrong");
  clear_flags_a: assert property (wdtClear && !wdtTimeout |=> !timeoutFlag && !powerDownFlag)
    else $error("flags not cleared by watchdog clear");
endmodule
bind rsfc_top rsfc_checker u_chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .supplyLow(supplyLow),
  .sleepMode(sleepMode), .wdtTimeout(wdtTimeout), .wdtWordBad(wdtWordBad),
  .haltEntry(haltEntry), .wdtClear(wdtClear), .regRdata(regRdata), .tripLevel(tripLevel),
  .lvrEnable(lvrEnable), .systemReset(systemReset), .pcStackClear(pcStackClear),
  .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag), .irq(irq));

// ===== tb/rsfc_top_tb_top.sv
// Purpose: self-checking bench for the reset source and flag controller
// Assumes: bench drives every port itself, register strobes one cycle long
// Notes: package timing counts are short enough to run in full
`timescale 1ns/1ns
module rsfc_top_tb_top;
  import rsfc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0, regRead = 1'b0, supplyLow = 1'b0, sleepMode = 1'b0;
  logic wdtTimeout = 1'b0, wdtWordBad = 1'b0, haltEntry = 1'b0, wdtClear = 1'b0;
  logic [7:0] regRdata;
  logic [1:0] tripLevel;
  logic lvrEnable, systemReset, pcStackClear, timeoutFlag, powerDownFlag, irq;
  int errors = 0; // mismatches
  int cmp_count = 0; // comparisons made
  int n; // cycles waited for a reset
  logic [7:0] trips [4] = '{TRIP_2V10, TRIP_2V55, TRIP_3V15, TRIP_3V80};
  rsfc_top u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .supplyLow(supplyLow), .sleepMode(sleepMode),
    .wdtTimeout(wdtTimeout), .wdtWordBad(wdtWordBad), .haltEntry(haltEntry),
    .wdtClear(wdtClear), .regRdata(regRdata), .tripLevel(tripLevel), .lvrEnable(lvrEnable),
    .systemReset(systemReset), .pcStackClear(pcStackClear), .timeoutFlag(timeoutFlag),
    .powerDownFlag(powerDownFlag), .irq(irq));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register write, taken at the second edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask
  // one-cycle event pulse; returns just after the taking edge
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: wdtTimeout <= 1'b1;
      1: haltEntry <= 1'b1;
      2: wdtClear <= 1'b1;
      default: wdtWordBad <= 1'b1;
    endcase
    @(posedge clk);
    {wdtTimeout, haltEntry, wdtClear, wdtWordBad} <= 4'h0;
    #1;
  endtask
  // bounded wait for a full reset, then its four-cycle length
  task automatic waitRst(input int lim);
    n = 0;
    while (systemReset !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    chk("reset rise", 8'h01, {7'h0, systemReset});
    repeat (4) @(posedge clk);
    #1 chk("reset fall", 8'h00, {7'h0, systemReset});
    repeat (2) @(posedge clk);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog: the whole run needs about 11000 cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("reset out", 8'h00, {7'h0, systemReset});
    chk("lvr enable", 8'h01, {7'h0, lvrEnable});
    rdChk("threshold por", OFS_THRESHOLD, THRESHOLD_POR);
    rdChk("flags por", OFS_FLAGS, 8'h00);
    rdChk("guard por", OFS_GUARD, GUARD_POR);
    rdChk("status por", OFS_STATUS, 8'h00);
    rdChk("unmapped", 4'hf, 8'h00);
    // every defined trip pattern, no corruption flagged
    for (int i = 0; i < 4; i++) begin
      wr(OFS_THRESHOLD, trips[i]);
      repeat (2) @(posedge clk);
      #1 chk("trip level", 8'(i), {6'h0, tripLevel});
    end
    rdChk("flags valid", OFS_FLAGS, 8'h00);
    // sleep watchdog with its interrupt unmasked
    wr(OFS_IRQ_MASK, 8'h10);
    sleepMode <= 1'b1;
    pulse(0);
    chk("stack clear", 8'h01, {7'h0, pcStackClear});
    chk("flags sleep", 8'h03, {6'h0, powerDownFlag, timeoutFlag});
    @(posedge clk);
    #1 chk("no full reset", 8'h00, {6'h0, systemReset, pcStackClear});
    chk("irq set", 8'h01, {7'h0, irq});
    chk("lvr off", 8'h00, {7'h0, lvrEnable});
    rdChk("threshold kept", OFS_THRESHOLD, TRIP_3V80);
    wr(OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 8'h00, {7'h0, irq});
    wr(OFS_IRQ_MASK, 8'h10);
    wr(OFS_IRQ_STAT, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", 8'h00, {7'h0, irq});
    pulse(2);
    rdChk("status clear", OFS_STATUS, 8'h00);
    @(posedge clk);
    sleepMode <= 1'b0;
    // run watchdog keeps power-down and reloads the threshold
    pulse(1);
    pulse(0);
    chk("flags run", 8'h03, {6'h0, powerDownFlag, timeoutFlag});
    waitRst(3);
    rdChk("threshold reload", OFS_THRESHOLD, THRESHOLD_POR);
    pulse(2);
    // short undervoltage is filtered out, a long one resets
    wr(OFS_THRESHOLD, TRIP_3V15);
    supplyLow <= 1'b1;
    repeat (UV_FILTER_CYC - 1000) @(posedge clk);
    supplyLow <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk("short drop", 8'h00, {7'h0, systemReset});
    @(posedge clk);
    supplyLow <= 1'b1;
    waitRst(UV_FILTER_CYC + 20);
    chk("filter time", 8'h01, {7'h0, n >= UV_FILTER_CYC});
    supplyLow <= 1'b0;
    rdChk("uv flag", OFS_FLAGS, 8'h04);
    rdChk("threshold held", OFS_THRESHOLD, TRIP_3V15);
    wr(OFS_FLAGS, 8'hfb);
    rdChk("uv cleared", OFS_FLAGS, 8'h00);
    // corrupted threshold: flag at once, reset after the soft delay
    wr(OFS_THRESHOLD, 8'h12);
    rdChk("thr flag", OFS_FLAGS, 8'h02);
    waitRst(SOFT_RESET_CYC + 20);
    chk("soft delay", 8'h01, {7'h0, n >= SOFT_RESET_CYC - 10});
    rdChk("threshold restore", OFS_THRESHOLD, THRESHOLD_POR);
    // corrupted guard word, then a bad watchdog word
    wr(OFS_GUARD, 8'h12);
    waitRst(SOFT_RESET_CYC + 20);
    rdChk("guard restore", OFS_GUARD, GUARD_POR);
    pulse(3);
    waitRst(SOFT_RESET_CYC + 20);
    rdChk("flags all", OFS_FLAGS, 8'h0b);
    wr(OFS_FLAGS, 8'h00);
    rdChk("flags cleared", OFS_FLAGS, 8'h00);
    test_done();
  end
endmodule
